// [hdl/ccap_capture_ctrl.sv]
`timescale 1ns/10ps
`include "ccap_map.svh"
module ccap_capture_ctrl (
   // Clock and reset
   input  wire logic                  aclk,
   input  wire logic                  aresetn,
   // Capture pins and group counter
   input  wire logic                  cap_pin2,
   input  wire logic                  cap_pin3,
   input  wire ccap_pkg::ccap_count_t group_count,
   // Interrupt
   output logic                       capture_irq,
   // AXI4-Lite write address
   input  wire logic [7:0]            s_axi_awaddr,
   input  wire logic                  s_axi_awvalid,
   output logic                       s_axi_awready,
   // AXI4-Lite write data
   input  wire logic [31:0]           s_axi_wdata,
   input  wire logic [3:0]            s_axi_wstrb,
   input  wire logic                  s_axi_wvalid,
   output logic                       s_axi_wready,
   // AXI4-Lite write response
   output logic [1:0]                 s_axi_bresp,
   output logic                       s_axi_bvalid,
   input  wire logic                  s_axi_bready,
   // AXI4-Lite read address
   input  wire logic [7:0]            s_axi_araddr,
   input  wire logic                  s_axi_arvalid,
   output logic                       s_axi_arready,
   // AXI4-Lite read data
   output logic [31:0]                s_axi_rdata,
   output logic [1:0]                 s_axi_rresp,
   output logic                       s_axi_rvalid,
   input  wire logic                  s_axi_rready
);

   // ----------------------------------------
   // State
   // ----------------------------------------
   logic [31:0]           ctrl;          // Control register image
   logic                  clear_mode;    // Indicator clear polarity (low density)
   logic                  low_density;   // Selects low-density clear behaviour
   ccap_pkg::ccap_count_t c2_rise;       // Channel 2 rising latch
   ccap_pkg::ccap_count_t c2_fall;       // Channel 2 falling latch
   ccap_pkg::ccap_count_t c3_rise;       // Channel 3 rising latch
   ccap_pkg::ccap_count_t c3_fall;       // Channel 3 falling latch
   logic [1:0]            sync_a;        // First synchroniser stage
   logic [1:0]            sync_b;        // Second synchroniser stage
   logic [1:0]            prev_lvl;      // Previous optionally inverted level
   logic [7:0]            aw_addr;       // Held write address
   logic                  aw_have;       // Write address taken
   logic [31:0]           w_data;        // Held write data
   logic [3:0]            w_strb;        // Held write strobes
   logic                  w_have;        // Write data taken
   ccap_pkg::ccap_wstate_t wstate;       // Write response state

   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   // Zero-extend a latch for reading
   function automatic logic [31:0] ext16(input ccap_pkg::ccap_count_t v);
      ext16 = {16'h0000, v};
   endfunction

   // New indicator value after a write; set wins over clear
   function automatic logic ind_next(input logic cur, input logic wbit,
                                     input logic wr, input logic set,
                                     input logic lowd, input logic mode);
      logic clr;
      clr = 1'b0;
      if (wr) begin
         if (lowd) begin
            clr = (wbit == mode);
         end else begin
            clr = ~wbit;
         end
      end
      ind_next = set | (cur & ~clr);
   endfunction

   // ----------------------------------------
   // Input path
   // ----------------------------------------
   logic [1:0] lvl;      // Synchronised, optionally inverted
   logic [1:0] rise_ev;  // Rising edge seen
   logic [1:0] fall_ev;  // Falling edge seen
   logic [1:0] cap_en;   // Capture enables per channel
   logic [1:0] rise_ie;  // Rising interrupt enables
   logic [1:0] fall_ie;  // Falling interrupt enables

   assign cap_en  = {ctrl[`CCAP_B_EN3], ctrl[`CCAP_B_EN2]};
   assign rise_ie = {ctrl[`CCAP_B_RIE3], ctrl[`CCAP_B_RIE2]};
   assign fall_ie = {ctrl[`CCAP_B_FIE3], ctrl[`CCAP_B_FIE2]};
   // Inversion before edge detection
   assign lvl[0]  = sync_b[0] ^ ctrl[`CCAP_B_CH2_INPUT_INVERT];
   assign lvl[1]  = sync_b[1] ^ ctrl[`CCAP_B_CH3_INPUT_INVERT];
   // Toggling the invert bit alone also makes an edge, as the pin would
   assign rise_ev = lvl & ~prev_lvl & cap_en;
   assign fall_ev = ~lvl & prev_lvl & cap_en;

   // Two-stage synchroniser; stage one is read only by stage two
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         sync_a <= 2'b00;
         sync_b <= 2'b00;
      end else begin
         sync_a <= {cap_pin3, cap_pin2};
         sync_b <= sync_a;
      end
   end

   // Level history for single detection of each edge
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         prev_lvl <= 2'b00;
      end else begin
         prev_lvl <= lvl;
      end
   end

   // Latch the counter on enabled edges
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         c2_rise <= `CCAP_LATCH_RST;
         c2_fall <= `CCAP_LATCH_RST;
         c3_rise <= `CCAP_LATCH_RST;
         c3_fall <= `CCAP_LATCH_RST;
      end else begin
         if (rise_ev[0]) begin
            c2_rise <= group_count;
         end
         if (fall_ev[0]) begin
            c2_fall <= group_count;
         end
         if (rise_ev[1]) begin
            c3_rise <= group_count;
         end
         if (fall_ev[1]) begin
            c3_fall <= group_count;
         end
      end
   end

   // ----------------------------------------
   // Write channel
   // ----------------------------------------
   logic do_write;   // Both halves held, perform write
   logic wr_ctrl;    // Write hits control register
   logic wr_mode;    // Write hits mode register
   logic wr_map;     // Write hits a mapped register

   assign do_write = aw_have & w_have & (wstate == ccap_pkg::CCAP_W_IDLE);
   assign wr_ctrl  = do_write & (aw_addr == `CCAP_OFS_CTRL);
   assign wr_mode  = do_write & (aw_addr == `CCAP_OFS_MODE);
   assign wr_map   = (aw_addr == `CCAP_OFS_CTRL) | (aw_addr == `CCAP_OFS_MODE)
                   | (aw_addr == `CCAP_OFS_C2_RISE) | (aw_addr == `CCAP_OFS_C2_FALL)
                   | (aw_addr == `CCAP_OFS_C3_RISE) | (aw_addr == `CCAP_OFS_C3_FALL);

   // Address and data accepted independently, in either order
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_have       <= 1'b0;
         aw_addr       <= 8'h00;
         s_axi_awready <= 1'b0;
      end else begin
         s_axi_awready <= ~aw_have & ~s_axi_awready;
         if (s_axi_awvalid && s_axi_awready) begin
            aw_have       <= 1'b1;
            aw_addr       <= s_axi_awaddr;
            s_axi_awready <= 1'b0;
         end else if (do_write) begin
            aw_have <= 1'b0;
         end
      end
   end

   // Write data capture
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         w_have       <= 1'b0;
         w_data       <= 32'h0000_0000;
         w_strb       <= 4'h0;
         s_axi_wready <= 1'b0;
      end else begin
         s_axi_wready <= ~w_have & ~s_axi_wready;
         if (s_axi_wvalid && s_axi_wready) begin
            w_have       <= 1'b1;
            w_data       <= s_axi_wdata;
            w_strb       <= s_axi_wstrb;
            s_axi_wready <= 1'b0;
         end else if (do_write) begin
            w_have <= 1'b0;
         end
      end
   end

   // Write response; unmapped address answers SLVERR
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         wstate       <= ccap_pkg::CCAP_W_IDLE;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= `CCAP_RESP_OKAY;
      end else begin
         case (wstate)
            ccap_pkg::CCAP_W_IDLE: begin
               if (do_write) begin
                  wstate       <= ccap_pkg::CCAP_W_RESP;
                  s_axi_bvalid <= 1'b1;
                  s_axi_bresp  <= wr_map ? `CCAP_RESP_OKAY : `CCAP_RESP_SLVERR;
               end
            end
            ccap_pkg::CCAP_W_RESP: begin
               if (s_axi_bready) begin
                  wstate       <= ccap_pkg::CCAP_W_IDLE;
                  s_axi_bvalid <= 1'b0;
               end
            end
            default: begin
               wstate       <= ccap_pkg::CCAP_W_IDLE;
               s_axi_bvalid <= 1'b0;
            end
         endcase
      end
   end

   // ----------------------------------------
   // Control register
   // ----------------------------------------
   logic lo_wr;   // Byte lane 0 written
   logic hi_wr;   // Byte lane 2 written

   assign lo_wr = wr_ctrl & w_strb[0];
   assign hi_wr = wr_ctrl & w_strb[2];

   // Config bits, indicators and flags; hardware set wins over clear
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ctrl <= `CCAP_CTRL_RST;
      end else begin
         if (lo_wr) begin
            ctrl[3:0] <= w_data[3:0];
         end
         if (hi_wr) begin
            ctrl[19:16] <= w_data[19:16];
         end
         ctrl[`CCAP_B_FLG2] <= ((rise_ev[0] & rise_ie[0]) | (fall_ev[0] & fall_ie[0]))
                             | (ctrl[`CCAP_B_FLG2] & ~(lo_wr & w_data[`CCAP_B_FLG2]));
         ctrl[`CCAP_B_FLG3] <= ((rise_ev[1] & rise_ie[1]) | (fall_ev[1] & fall_ie[1]))
                             | (ctrl[`CCAP_B_FLG3] & ~(hi_wr & w_data[`CCAP_B_FLG3]));
         ctrl[`CCAP_B_RLI2] <= ind_next(ctrl[`CCAP_B_RLI2], w_data[`CCAP_B_RLI2], lo_wr,
                                        rise_ev[0], low_density, clear_mode);
         ctrl[`CCAP_B_FLI2] <= ind_next(ctrl[`CCAP_B_FLI2], w_data[`CCAP_B_FLI2], lo_wr,
                                        fall_ev[0], low_density, clear_mode);
         ctrl[`CCAP_B_RLI3] <= ind_next(ctrl[`CCAP_B_RLI3], w_data[`CCAP_B_RLI3], hi_wr,
                                        rise_ev[1], low_density, clear_mode);
         ctrl[`CCAP_B_FLI3] <= ind_next(ctrl[`CCAP_B_FLI3], w_data[`CCAP_B_FLI3], hi_wr,
                                        fall_ev[1], low_density, clear_mode);
         ctrl[5]     <= 1'b0;
         ctrl[15:8]  <= 8'h00;
         ctrl[21]    <= 1'b0;
         ctrl[31:24] <= 8'h00;
      end
   end

   // Mode register: clear polarity and variant select
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         clear_mode  <= 1'b0;
         low_density <= 1'b0;
      end else if (wr_mode && w_strb[0]) begin
         clear_mode  <= w_data[`CCAP_B_CLRMODE];
         low_density <= w_data[`CCAP_B_LOWDENS];
      end
   end

   // Interrupt: flag only counts while its channel is enabled
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         capture_irq <= 1'b0;
      end else begin
         capture_irq <= (ctrl[`CCAP_B_FLG2] & ctrl[`CCAP_B_EN2])
                      | (ctrl[`CCAP_B_FLG3] & ctrl[`CCAP_B_EN3]);
      end
   end

   // ----------------------------------------
   // Read channel
   // ----------------------------------------
   logic [31:0] rd_val;  // Decoded read value
   logic        rd_ok;   // Read hits a mapped register

   // Read decode
   always_comb begin
      rd_ok  = 1'b1;
      rd_val = 32'h0000_0000;
      case (s_axi_araddr)
         `CCAP_OFS_CTRL:    rd_val = ctrl;
         `CCAP_OFS_C2_RISE: rd_val = ext16(c2_rise);
         `CCAP_OFS_C2_FALL: rd_val = ext16(c2_fall);
         `CCAP_OFS_C3_RISE: rd_val = ext16(c3_rise);
         `CCAP_OFS_C3_FALL: rd_val = ext16(c3_fall);
         `CCAP_OFS_MODE:    rd_val = {30'h0000_0000, low_density, clear_mode};
         default:           rd_ok  = 1'b0;
      endcase
   end

   // One read at a time; arready pulses when idle
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h0000_0000;
         s_axi_rresp   <= `CCAP_RESP_OKAY;
      end else begin
         // Ready must not wait for valid to drop, or a held request stalls
         s_axi_arready <= ~s_axi_rvalid & ~s_axi_arready;
         if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b1;
            s_axi_rdata   <= rd_val;
            s_axi_rresp   <= rd_ok ? `CCAP_RESP_OKAY : `CCAP_RESP_SLVERR;
         end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end

endmodule

// [hdl/ccap_map.svh]
`ifndef CCAP_MAP_SVH
`define CCAP_MAP_SVH

// ----------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------
`define CCAP_OFS_CTRL      8'h00
`define CCAP_OFS_C2_RISE   8'h04
`define CCAP_OFS_C2_FALL   8'h08
`define CCAP_OFS_C3_RISE   8'h0c
`define CCAP_OFS_C3_FALL   8'h10
`define CCAP_OFS_MODE      8'h14

// ----------------------------------------
// Control register fields
// ----------------------------------------
`define CCAP_B_CH2_INPUT_INVERT        0
`define CCAP_B_RIE2        1
`define CCAP_B_FIE2        2
`define CCAP_B_EN2         3
`define CCAP_B_FLG2        4
`define CCAP_B_RLI2        6
`define CCAP_B_FLI2        7
`define CCAP_B_CH3_INPUT_INVERT        16
`define CCAP_B_RIE3        17
`define CCAP_B_FIE3        18
`define CCAP_B_EN3         19
`define CCAP_B_FLG3        20
`define CCAP_B_RLI3        22
`define CCAP_B_FLI3        23

// Mode register: bit 0 clear mode, bit 1 low-density variant
`define CCAP_B_CLRMODE     0
`define CCAP_B_LOWDENS     1

// ----------------------------------------
// Reset values and bus answers
// ----------------------------------------
`define CCAP_CTRL_RST      32'h0000_0000
`define CCAP_LATCH_RST     16'h0000
`define CCAP_RESP_OKAY     2'b00
`define CCAP_RESP_SLVERR   2'b10

`endif

// [hdl/ccap_pkg.sv]
package ccap_pkg;
   // Counter width of the group down-counter
   typedef logic [15:0] ccap_count_t;
   // Write-side handshake state, Gray along the path
   typedef enum logic [1:0] {
      CCAP_W_IDLE = 2'b00,
      CCAP_W_RESP = 2'b01
   } ccap_wstate_t;
endpackage

// [test/ccap_capture_properties.sv]
`timescale 1ns/10ps
module ccap_capture_checker (
   // Clock and reset
   input wire logic        aclk,
   input wire logic        aresetn,
   // Pins and interrupt
   input wire logic        cap_pin2,
   input wire logic        cap_pin3,
   input wire logic        capture_irq,
   // Bus handshakes
   input wire logic        s_axi_wvalid,
   input wire logic        s_axi_wready,
   input wire logic        s_axi_awvalid,
   input wire logic        s_axi_awready,
   input wire logic        s_axi_bvalid,
   input wire logic        s_axi_bready,
   input wire logic [1:0]  s_axi_bresp,
   input wire logic        s_axi_arvalid,
   input wire logic        s_axi_arready,
   input wire logic [7:0]  s_axi_araddr,
   input wire logic        s_axi_rvalid,
   input wire logic        s_axi_rready,
   input wire logic [1:0]  s_axi_rresp,
   input wire logic [31:0] s_axi_rdata
);
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   logic [3:0] quiet;  // Cycles since a pin moved or a write landed
   logic [1:0] pin_q;  // Pins at the previous edge
   // Activity counter, saturating so it never wraps into a false cause
   always_ff @(posedge aclk) begin
      pin_q <= {cap_pin3, cap_pin2};
      if (!aresetn || pin_q != {cap_pin3, cap_pin2} || (s_axi_wvalid && s_axi_wready))
         quiet <= 4'h0;
      else if (quiet != 4'hf)
         quiet <= quiet + 4'h1;
   end
   a_b_holds:
      assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write response dropped early");
   a_r_holds:
      assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read data dropped early");
   a_r_follows:
      assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read data late");
   a_b_follows:
      assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
                       |-> ##[1:4] s_axi_bvalid)
      else $error("write response late");
   a_reset_quiet:
      assert property ($rose(aresetn) |-> !capture_irq && !s_axi_bvalid && !s_axi_rvalid)
      else $error("outputs active after reset");
   a_irq_cause:
      assert property ($rose(capture_irq) |-> quiet < 4'd10)
      else $error("interrupt rose without cause");
   a_irq_steady:
      assert property (quiet > 4'd10 |-> $stable(capture_irq))
      else $error("interrupt moved while idle");
   a_ctrl_reserved:
      assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr == 8'h00
                       |=> (s_axi_rdata & 32'hff20ff20) == 32'h0)
      else $error("reserved control bits set");
   a_unmapped_err:
      assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr > 8'h14
                       |=> s_axi_rresp == 2'b10)
      else $error("unmapped read not refused");
   c_irq: cover property ($rose(capture_irq));
   c_wr: cover property (s_axi_bvalid && s_axi_bready);
   c_err: cover property (s_axi_rvalid && s_axi_rready && s_axi_rresp == 2'b10);
endmodule
bind ccap_capture_ctrl ccap_capture_checker chk (.aclk(aclk), .aresetn(aresetn),
   .cap_pin2(cap_pin2), .cap_pin3(cap_pin3), .capture_irq(capture_irq),
   .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
   .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
   .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_bresp(s_axi_bresp),
   .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
   .s_axi_araddr(s_axi_araddr), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
   .s_axi_rresp(s_axi_rresp), .s_axi_rdata(s_axi_rdata));

// [test/ccap_pin_model.sv]
`timescale 1ns/10ps
// ----------------------------------------
// Far side: capture pins and group counter
// ----------------------------------------
module ccap_pin_model (
   // Toward the block
   output logic                  cap_pin2,
   output logic                  cap_pin3,
   output ccap_pkg::ccap_count_t group_count
);
   // Idle pins low, counter at top
   initial begin
      cap_pin2 = 1'b0;
      cap_pin3 = 1'b0;
      group_count = 16'hffff;
   end
   // Counter moves on the edge, pins off the clock grid like a raw port
   task automatic drive(input logic [1:0] p, input ccap_pkg::ccap_count_t c);
      group_count <= c;
      #1.3;
      cap_pin2 = p[0];
      cap_pin3 = p[1];
   endtask
endmodule

// [test/test_capture_ctrl_ch2_ch3.sv]
`timescale 1ns/10ps
`include "ccap_map.svh"
`define CHK(n, e, g) begin checks_done++; if ((g) !== (e)) begin fail_count++; \
   $display("unexpected %s exp %h got %h", n, e, g); end end
module test_capture_ctrl_ch2_ch3;
   logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
   logic [7:0]  awaddr, araddr;
   logic [31:0] wdata, rng, rd, m_ctrl;
   logic [3:0]  wstrb;
   logic [1:0]  rsp, m_mode, m_pin;
   logic [15:0] m_lat [4];  // Rise/fall latches of channel 2, then 3
   logic [15:0] m_cnt;      // Counter value the partner shows
   wire         awready, wready, bvalid, arready, rvalid, irq, pin2, pin3;
   wire [1:0]   bresp, rresp;
   wire [31:0]  rdata;
   wire ccap_pkg::ccap_count_t cnt;
   int          fail_count, checks_done;
   ccap_capture_ctrl uut (.aclk(aclk), .aresetn(aresetn), .cap_pin2(pin2), .cap_pin3(pin3),
      .group_count(cnt), .capture_irq(irq), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
      .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
      .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
      .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
      .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
   ccap_pin_model pins (.cap_pin2(pin2), .cap_pin3(pin3), .group_count(cnt));
   // ----------------------------------------
   // Reference model
   // ----------------------------------------
   function automatic logic [31:0] xs(input logic [31:0] s);
      s ^= s << 13;
      s ^= s >> 17;
      s ^= s << 5;
      return s;
   endfunction
   // One detected edge on channel at bit base b
   task automatic m_edge(input int b, input logic rise);
      if (m_ctrl[b+3]) begin
         m_lat[b/8 + (rise ? 0 : 1)] = m_cnt;
         m_ctrl[b + (rise ? 6 : 7)] = 1'b1;
         if (m_ctrl[b + (rise ? 1 : 2)]) m_ctrl[b+4] = 1'b1;
      end
   endtask
   // Control write; a changed invert bit acts as an edge
   task automatic m_wr(input logic [31:0] w);
      logic o;
      logic cv;
      cv = m_mode[1] & m_mode[0];
      for (int b = 0; b <= 16; b += 16) begin
         o = m_pin[b/16] ^ m_ctrl[b];
         m_ctrl[b +: 4] = w[b +: 4];
         if (w[b+4]) m_ctrl[b+4] = 1'b0;
         for (int i = 6; i < 8; i++) if (w[b+i] == cv) m_ctrl[b+i] = 1'b0;
         if ((m_pin[b/16] ^ m_ctrl[b]) != o) m_edge(b, ~o);
      end
   endtask
   // ----------------------------------------
   // Bus master and checks
   // ----------------------------------------
   task automatic conclude();
      $display("checks %0d mismatches %0d", checks_done, fail_count);
      if (fail_count == 0 && checks_done > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
      int i;
      @(posedge aclk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      for (i = 0; i < 64; i++) begin
         @(posedge aclk);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
         if (bvalid) break;
      end
      r = bresp;
      bready <= 1'b0;
      if (i == 64) begin fail_count++; conclude(); end
   endtask
   task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      int i;
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      for (i = 0; i < 64; i++) begin
         @(posedge aclk);
         if (arready) arvalid <= 1'b0;
         if (rvalid) break;
      end
      d = rdata;
      r = rresp;
      rready <= 1'b0;
      if (i == 64) begin fail_count++; conclude(); end
   endtask
   task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
      axi_rd(a, rd, rsp);
      `CHK("rdata", e, rd)
      `CHK("rresp", `CCAP_RESP_OKAY, rsp)
   endtask
   initial begin
      aclk = 1'b0;
      forever #2 aclk = ~aclk;
   end
   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial begin
      {aresetn, awvalid, wvalid, bready, arvalid, rready, awaddr, araddr, wdata} = '0;
      wstrb = 4'hf;
      rng = 32'hbd92dbc5;
      {m_ctrl, m_mode, m_pin, m_cnt} = '0;
      m_cnt = 16'hffff;  // Partner idles its counter at the top
      m_lat = '{default: 16'h0};
      repeat (20) @(posedge aclk);
      aresetn <= 1'b1;
      rd_chk(`CCAP_OFS_CTRL, `CCAP_CTRL_RST);
      rd_chk(`CCAP_OFS_C3_FALL, 32'h0);
      axi_rd(8'h18, rd, rsp);
      `CHK("bad rresp", `CCAP_RESP_SLVERR, rsp)
      axi_wr(8'h18, 32'hffffffff, rsp);
      `CHK("bad bresp", `CCAP_RESP_SLVERR, rsp)
      for (int k = 0; k < 40; k++) begin
         rng = xs(rng);
         if (rng[31:29] == 3'h0 || k == 20) begin
            m_mode = rng[1:0];
            axi_wr(`CCAP_OFS_MODE, {30'h0, m_mode}, rsp);
            rd_chk(`CCAP_OFS_MODE, {30'h0, m_mode});
         end
         rng = xs(rng);
         axi_wr(`CCAP_OFS_CTRL, rng, rsp);
         `CHK("bresp", `CCAP_RESP_OKAY, rsp)
         m_wr(rng);
         repeat (8) @(posedge aclk);
         rng = xs(rng);
         m_cnt = rng[31:16];
         pins.drive(rng[1:0], rng[31:16]);
         for (int c = 0; c < 2; c++)
            if (rng[c] != m_pin[c]) m_edge(16 * c, rng[c] ^ m_ctrl[16 * c]);
         m_pin = rng[1:0];
         repeat (8) @(posedge aclk);
         `CHK("irq", (m_ctrl[4] & m_ctrl[3]) | (m_ctrl[20] & m_ctrl[19]), irq)
         axi_wr(`CCAP_OFS_C2_RISE, rng, rsp);
         `CHK("latch bresp", `CCAP_RESP_OKAY, rsp)
         rd_chk(`CCAP_OFS_CTRL, m_ctrl);
         for (int j = 0; j < 4; j++)
            rd_chk(8'h04 + 8'(4 * j), {16'h0, m_lat[j]});
      end
      conclude();
   end
endmodule
